// ===== src/cpu_dp_defs.svh
`ifndef CPU_DP_DEFS_SVH
`define CPU_DP_DEFS_SVH

// ----------------------------------------------------------------------------
// Flag and field positions
// ----------------------------------------------------------------------------
`define CCR_I 7
`define CCR_H 5
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0
`define EXR_T 7
`define EXR_I_HI 2
`define EXR_I_LO 0
`define EXR_RST 8'h07
`define EXR_MASK_SET 3'h7
`define ACCUMULATOR_UPPER_HALF_VALID_W 10
`define HC_B 4
`define HC_W 12
`define HC_L 28
`define MSB_B 5'h07
`define MSB_W 5'h0f
`define MSB_L 5'h1f
`define MASK_B 32'h0000_00ff
`define MASK_W 32'h0000_ffff
`define MASK_L 32'hffff_ffff
`define BCD_DIGIT_MAX 4'h9
`define BCD_BYTE_MAX 8'h99
`define BCD_ADJ_LO 8'h06
`define BCD_ADJ_HI 8'h60
`define STEP_W 32'h0000_0002
`define STEP_L 32'h0000_0004
`define ALIGN_MASK 32'hffff_fffe
`define ST_VEC 2'h1
`define ST_RUN 2'h2

// ----------------------------------------------------------------------------
// Instruction class sizes
// ----------------------------------------------------------------------------
`define N_TYPES 69
`define N_LOGIC 4
`define N_SHIFT 8
`endif

// ===== src/cpu_dp_pkg.sv
`include "cpu_dp_defs.svh"
package cpu_dp_pkg;
  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} size_t;

  // The ops below are the ones this datapath decodes, OP_SYNC_RD and OP_SYNC_WR only to raise bad_op_r; the full set spans 69
  // types in eight classes, the rest being handled elsewhere in the core.
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
    OP_AND, OP_OR, OP_XOR, OP_NOT,
    OP_SHAL, OP_SHAR, OP_SHLL, OP_SHLR, OP_ROTL, OP_ROTR, OP_ROTXL, OP_ROTXR,
    OP_BSET, OP_BCLR, OP_BNOT, OP_BTST, OP_BLD, OP_BILD, OP_BST, OP_BIST,
    OP_BAND, OP_BIAND, OP_BOR, OP_BIOR, OP_BXOR, OP_BIXOR,
    OP_DAA, OP_DAS, OP_MAC, OP_LDMACH, OP_LDMACL, OP_CLRMAC, OP_STMACH, OP_STMACL,
    OP_LDC, OP_STC, OP_PUSH, OP_POP, OP_LDSP, OP_SYNC_RD, OP_SYNC_WR
  } op_t;

  typedef enum logic [1:0] {ST_VEC = `ST_VEC, ST_RUN = `ST_RUN} state_t;

  typedef struct packed {
    op_t op;
    size_t size;
    logic [31:0] a;
    logic [31:0] b;
    logic [2:0] bit_idx;
  } req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    size_t size;
    logic fetch;
  } acc_t;
endpackage

// ===== src/add_unit.sv
`timescale 1ns/10ps
`include "cpu_dp_defs.svh"
module add_unit (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic cin,
  input wire logic sub,
  input wire cpu_dp_pkg::size_t size,
  // Result and flags
  output logic [31:0] res,
  output logic c,
  output logic v,
  output logic h
);
  logic [31:0] bb;
  logic [32:0] s;
  logic [32:0] cv;
  logic ci;

  // Subtraction is a + ~b + ~borrow, so carry and half-carry invert into borrows.
  always_comb begin
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s = {1'b0, a} + {1'b0, bb} + {32'h0, ci};
    cv = {1'b0, a} ^ {1'b0, bb} ^ s;
    res = s[31:0];
    case (size)
      cpu_dp_pkg::SZ_B: begin
        c = cv[`MSB_B + 1] ^ sub;
        v = cv[`MSB_B + 1] ^ cv[`MSB_B];
        h = cv[`HC_B] ^ sub;
      end
      cpu_dp_pkg::SZ_W: begin
        c = cv[`MSB_W + 1] ^ sub;
        v = cv[`MSB_W + 1] ^ cv[`MSB_W];
        h = cv[`HC_W] ^ sub;
      end
      default: begin
        c = cv[`MSB_L + 1] ^ sub;
        v = cv[`MSB_L + 1] ^ cv[`MSB_L];
        h = cv[`HC_L] ^ sub;
      end
    endcase
  end
endmodule

// ===== src/cpu_flags_mac_dp.sv
`timescale 1ns/10ps
`include "cpu_dp_defs.svh"
module cpu_flags_mac_dp #(
  parameter int ACCUMULATOR_UPPER_HALF_W = `ACCUMULATOR_UPPER_HALF_VALID_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Reset vector
  input wire logic vec_valid,
  input wire logic [31:0] vec_addr,
  // Operations
  input wire logic req_valid,
  input wire cpu_dp_pkg::req_t req,
  // Memory accesses and fetches
  input wire cpu_dp_pkg::acc_t acc,
  // Exceptions and interrupts
  input wire logic exc_start,
  input wire logic irq_req,
  input wire logic nmi_req,
  // Results
  output logic [31:0] res_r,
  output logic done_r,
  output logic bad_op_r,
  output logic [7:0] ccr_r,
  output logic [7:0] exr_r,
  output logic [31:0] pc_r,
  output logic [31:0] sp_r,
  output logic [31:0] accumulator_upper_half_r,
  output logic [31:0] accumulator_lower_half_r,
  // Memory request
  output logic [31:0] mem_addr_r,
  output logic mem_req_r,
  output logic mem_wr_r,
  output logic vec_req_r,
  output logic irq_take_r
);
  localparam int AW = 32 + ACCUMULATOR_UPPER_HALF_W;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  cpu_dp_pkg::state_t seq_r, seq_nxt;
  logic [31:0] pc_nxt, sp_nxt, res_nxt, accumulator_upper_half_nxt, accumulator_lower_half_nxt, maddr_nxt;
  logic [7:0] ccr_nxt, exr_nxt;
  logic imask_r;
  logic [6:0] flags_r;
  logic done_nxt, bad_nxt, mreq_nxt, mwr_nxt, vreq_nxt, irq_nxt;
  logic [31:0] m, r, au_a, au_res, step, acc_addr;
  logic [4:0] msb;
  logic [7:0] bt, adj;
  logic au_cin, au_sub, au_c, au_v, au_h, bv, cf, run;
  logic signed [31:0] prod;
  logic [AW-1:0] acc_sum;

  assign run = seq_r == cpu_dp_pkg::ST_RUN;
  assign ccr_r = {imask_r, flags_r};
  assign acc_addr = acc.addr;
  assign bv = req.b[req.bit_idx];

  function automatic logic [31:0] sz_mask(input cpu_dp_pkg::size_t s);
    case (s)
      cpu_dp_pkg::SZ_B: sz_mask = `MASK_B;
      cpu_dp_pkg::SZ_W: sz_mask = `MASK_W;
      default: sz_mask = `MASK_L;
    endcase
  endfunction

  function automatic logic [4:0] sz_msb(input cpu_dp_pkg::size_t s);
    case (s)
      cpu_dp_pkg::SZ_B: sz_msb = `MSB_B;
      cpu_dp_pkg::SZ_W: sz_msb = `MSB_W;
      default: sz_msb = `MSB_L;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Adder
  // --------------------------------------------------------------------------
  always_comb begin
    au_a = (req.op == cpu_dp_pkg::OP_NEG) ? 32'h0 : req.a;
    au_sub = req.op inside {cpu_dp_pkg::OP_SUB, cpu_dp_pkg::OP_SUBX,
                            cpu_dp_pkg::OP_CMP, cpu_dp_pkg::OP_NEG};
    au_cin = (req.op inside {cpu_dp_pkg::OP_ADDX, cpu_dp_pkg::OP_SUBX}) ?
             ccr_r[`CCR_C] : 1'b0;
  end

  add_unit u_add (
    .a(au_a),
    .b(req.b),
    .cin(au_cin),
    .sub(au_sub),
    .size(req.size),
    .res(au_res),
    .c(au_c),
    .v(au_v),
    .h(au_h)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    seq_nxt = seq_r;
    pc_nxt = pc_r;
    exr_nxt = exr_r;
    ccr_nxt = ccr_r;
    sp_nxt = sp_r;
    accumulator_upper_half_nxt = accumulator_upper_half_r;
    accumulator_lower_half_nxt = accumulator_lower_half_r;
    res_nxt = res_r;
    maddr_nxt = mem_addr_r;
    done_nxt = 1'b0;
    bad_nxt = 1'b0;
    mreq_nxt = 1'b0;
    mwr_nxt = 1'b0;
    vreq_nxt = 1'b0;
    // The mask is sampled from the register, so a load of the mask bit takes
    // effect on the following request; this keeps the gate off the ALU path.
    irq_nxt = nmi_req | (irq_req & ~ccr_r[`CCR_I]);
    m = sz_mask(req.size);
    msb = sz_msb(req.size);
    step = (req.size == cpu_dp_pkg::SZ_L) ? `STEP_L : `STEP_W;
    r = 32'h0;
    bt = req.b[7:0];
    adj = 8'h0;
    cf = ccr_r[`CCR_C];
    prod = $signed(req.a[15:0]) * $signed(req.b[15:0]);
    acc_sum = {accumulator_upper_half_r[ACCUMULATOR_UPPER_HALF_W-1:0], accumulator_lower_half_r} + {{ACCUMULATOR_UPPER_HALF_W{prod[31]}}, prod};
    case (seq_r)
      cpu_dp_pkg::ST_VEC: begin
        vreq_nxt = ~vec_valid;
        if (vec_valid) begin
          pc_nxt = vec_addr & `ALIGN_MASK;
          exr_nxt[`EXR_T] = 1'b0;
          exr_nxt[`EXR_I_HI:`EXR_I_LO] = `EXR_MASK_SET;
          ccr_nxt[`CCR_I] = 1'b1;
          seq_nxt = cpu_dp_pkg::ST_RUN;
        end
      end
      cpu_dp_pkg::ST_RUN: begin
        if (acc.valid) begin
          mreq_nxt = 1'b1;
          if (acc.fetch) begin
            maddr_nxt = acc.addr & `ALIGN_MASK;
          end else if (acc.size != cpu_dp_pkg::SZ_B) begin
            maddr_nxt = acc.addr & `ALIGN_MASK;
          end else begin
            maddr_nxt = acc.addr;
          end
        end
        if (req_valid) begin
          done_nxt = 1'b1;
          case (req.op)
            cpu_dp_pkg::OP_ADD, cpu_dp_pkg::OP_ADDX, cpu_dp_pkg::OP_SUB,
            cpu_dp_pkg::OP_SUBX, cpu_dp_pkg::OP_CMP, cpu_dp_pkg::OP_NEG: begin
              r = au_res;
              ccr_nxt[`CCR_H] = au_h;
              ccr_nxt[`CCR_V] = au_v;
              cf = au_c;
              ccr_nxt[`CCR_N] = r[msb];
              ccr_nxt[`CCR_Z] = (r & m) == 32'h0;
              if (req.op != cpu_dp_pkg::OP_CMP) begin
                res_nxt = r & m;
              end
            end
            cpu_dp_pkg::OP_AND, cpu_dp_pkg::OP_OR,
            cpu_dp_pkg::OP_XOR, cpu_dp_pkg::OP_NOT: begin
              case (req.op)
                cpu_dp_pkg::OP_AND: r = req.a & req.b;
                cpu_dp_pkg::OP_OR: r = req.a | req.b;
                cpu_dp_pkg::OP_XOR: r = req.a ^ req.b;
                default: r = ~req.a;
              endcase
              ccr_nxt[`CCR_V] = 1'b0;
              ccr_nxt[`CCR_N] = r[msb];
              ccr_nxt[`CCR_Z] = (r & m) == 32'h0;
              res_nxt = r & m;
            end
            cpu_dp_pkg::OP_SHAL, cpu_dp_pkg::OP_SHAR, cpu_dp_pkg::OP_SHLL,
            cpu_dp_pkg::OP_SHLR, cpu_dp_pkg::OP_ROTL, cpu_dp_pkg::OP_ROTR,
            cpu_dp_pkg::OP_ROTXL, cpu_dp_pkg::OP_ROTXR: begin
              ccr_nxt[`CCR_V] = 1'b0;
              case (req.op)
                cpu_dp_pkg::OP_SHAL, cpu_dp_pkg::OP_SHLL: begin
                  r = req.a << 1;
                  cf = req.a[msb];
                  if (req.op == cpu_dp_pkg::OP_SHAL) begin
                    ccr_nxt[`CCR_V] = req.a[msb] ^ req.a[msb - 5'h01];
                  end
                end
                cpu_dp_pkg::OP_SHLR: begin
                  r = (req.a & m) >> 1;
                  cf = req.a[0];
                end
                cpu_dp_pkg::OP_SHAR: begin
                  r = ((req.a & m) >> 1) | ({31'h0, req.a[msb]} << msb);
                  cf = req.a[0];
                end
                cpu_dp_pkg::OP_ROTL: begin
                  r = (req.a << 1) | {31'h0, req.a[msb]};
                  cf = req.a[msb];
                end
                cpu_dp_pkg::OP_ROTR: begin
                  r = ((req.a & m) >> 1) | ({31'h0, req.a[0]} << msb);
                  cf = req.a[0];
                end
                cpu_dp_pkg::OP_ROTXL: begin
                  r = (req.a << 1) | {31'h0, ccr_r[`CCR_C]};
                  cf = req.a[msb];
                end
                default: begin
                  r = ((req.a & m) >> 1) | ({31'h0, ccr_r[`CCR_C]} << msb);
                  cf = req.a[0];
                end
              endcase
              ccr_nxt[`CCR_N] = r[msb];
              ccr_nxt[`CCR_Z] = (r & m) == 32'h0;
              res_nxt = r & m;
            end
            cpu_dp_pkg::OP_BSET: res_nxt = {24'h0, bt | (8'h1 << req.bit_idx)};
            cpu_dp_pkg::OP_BCLR: res_nxt = {24'h0, bt & ~(8'h1 << req.bit_idx)};
            cpu_dp_pkg::OP_BNOT: res_nxt = {24'h0, bt ^ (8'h1 << req.bit_idx)};
            cpu_dp_pkg::OP_BTST: ccr_nxt[`CCR_Z] = ~bv;
            cpu_dp_pkg::OP_BLD: cf = bv;
            cpu_dp_pkg::OP_BILD: cf = ~bv;
            cpu_dp_pkg::OP_BST, cpu_dp_pkg::OP_BIST: begin
              bt[req.bit_idx] = ccr_r[`CCR_C] ^ (req.op == cpu_dp_pkg::OP_BIST);
              res_nxt = {24'h0, bt};
            end
            cpu_dp_pkg::OP_BAND: cf = ccr_r[`CCR_C] & bv;
            cpu_dp_pkg::OP_BIAND: cf = ccr_r[`CCR_C] & ~bv;
            cpu_dp_pkg::OP_BOR: cf = ccr_r[`CCR_C] | bv;
            cpu_dp_pkg::OP_BIOR: cf = ccr_r[`CCR_C] | ~bv;
            cpu_dp_pkg::OP_BXOR: cf = ccr_r[`CCR_C] ^ bv;
            cpu_dp_pkg::OP_BIXOR: cf = ccr_r[`CCR_C] ^ ~bv;
            cpu_dp_pkg::OP_DAA, cpu_dp_pkg::OP_DAS: begin
              if (req.op == cpu_dp_pkg::OP_DAA) begin
                if (ccr_r[`CCR_H] || req.a[3:0] > `BCD_DIGIT_MAX) begin
                  adj = adj | `BCD_ADJ_LO;
                end
                if (ccr_r[`CCR_C] || req.a[7:0] > `BCD_BYTE_MAX) begin
                  adj = adj | `BCD_ADJ_HI;
                  cf = 1'b1;
                end
                r = {24'h0, req.a[7:0] + adj};
              end else begin
                if (ccr_r[`CCR_H]) begin
                  adj = adj | `BCD_ADJ_LO;
                end
                if (ccr_r[`CCR_C]) begin
                  adj = adj | `BCD_ADJ_HI;
                end
                r = {24'h0, req.a[7:0] - adj};
              end
              ccr_nxt[`CCR_N] = r[`MSB_B];
              ccr_nxt[`CCR_Z] = r[7:0] == 8'h0;
              res_nxt = r;
            end
            cpu_dp_pkg::OP_MAC: begin
              accumulator_upper_half_nxt = {{(64 - AW){acc_sum[AW-1]}}, acc_sum[AW-1:32]};
              accumulator_lower_half_nxt = acc_sum[31:0];
            end
            cpu_dp_pkg::OP_LDMACH: begin
              accumulator_upper_half_nxt = {{(32 - ACCUMULATOR_UPPER_HALF_W){req.a[ACCUMULATOR_UPPER_HALF_W-1]}}, req.a[ACCUMULATOR_UPPER_HALF_W-1:0]};
            end
            cpu_dp_pkg::OP_LDMACL: accumulator_lower_half_nxt = req.a;
            cpu_dp_pkg::OP_CLRMAC: begin
              accumulator_upper_half_nxt = 32'h0;
              accumulator_lower_half_nxt = 32'h0;
            end
            cpu_dp_pkg::OP_STMACH: res_nxt = accumulator_upper_half_r;
            cpu_dp_pkg::OP_STMACL: res_nxt = accumulator_lower_half_r;
            cpu_dp_pkg::OP_LDC: begin
              ccr_nxt = req.a[7:0];
              cf = req.a[`CCR_C];
            end
            cpu_dp_pkg::OP_STC: res_nxt = {24'h0, ccr_r};
            cpu_dp_pkg::OP_PUSH: begin
              sp_nxt = sp_r - step;
              maddr_nxt = (sp_r - step) & `ALIGN_MASK;
              mreq_nxt = 1'b1;
              mwr_nxt = 1'b1;
              res_nxt = req.a & m;
            end
            cpu_dp_pkg::OP_POP: begin
              maddr_nxt = sp_r & `ALIGN_MASK;
              sp_nxt = sp_r + step;
              mreq_nxt = 1'b1;
            end
            cpu_dp_pkg::OP_LDSP: sp_nxt = req.a;
            cpu_dp_pkg::OP_SYNC_RD, cpu_dp_pkg::OP_SYNC_WR: begin
              done_nxt = 1'b0;
              bad_nxt = 1'b1;
            end
            cpu_dp_pkg::OP_NOP: r = 32'h0;
            default: begin
              done_nxt = 1'b0;
              bad_nxt = 1'b1;
            end
          endcase
          ccr_nxt[`CCR_C] = cf;
        end
        // An exception start wins over a flag load in the same cycle.
        if (exc_start) begin
          ccr_nxt[`CCR_I] = 1'b1;
        end
      end
      default: seq_nxt = cpu_dp_pkg::ST_VEC;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers with a defined reset value
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_r <= cpu_dp_pkg::ST_VEC;
      pc_r <= 32'h0;
      exr_r <= `EXR_RST;
      imask_r <= 1'b1;
      accumulator_upper_half_r <= 32'h0;
      accumulator_lower_half_r <= 32'h0;
      res_r <= 32'h0;
      mem_addr_r <= 32'h0;
      done_r <= 1'b0;
      bad_op_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_wr_r <= 1'b0;
      vec_req_r <= 1'b0;
      irq_take_r <= 1'b0;
    end else if (ce) begin
      seq_r <= seq_nxt;
      pc_r <= pc_nxt;
      exr_r <= exr_nxt;
      imask_r <= ccr_nxt[`CCR_I];
      accumulator_upper_half_r <= accumulator_upper_half_nxt;
      accumulator_lower_half_r <= accumulator_lower_half_nxt;
      res_r <= res_nxt;
      mem_addr_r <= maddr_nxt;
      done_r <= done_nxt;
      bad_op_r <= bad_nxt;
      mem_req_r <= mreq_nxt;
      mem_wr_r <= mwr_nxt;
      vec_req_r <= vreq_nxt;
      irq_take_r <= irq_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Registers that reset leaves undefined
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      flags_r <= ccr_nxt[`CCR_I-1:0];
      sp_r <= sp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_zero;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_SUB && req.a == req.b
      |=> ccr_r[`CCR_Z] && res_r == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not set");

  property p_ovf;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_ADD && req.size == cpu_dp_pkg::SZ_B
      && req.a[7] == req.b[7]
      |=> ccr_r[`CCR_V] == (res_r[7] != $past(au_a[7]));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_shcarry;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_SHLR |=> ccr_r[`CCR_C] == $past(au_a[0]);
  endproperty
  a_shcarry: assert property (p_shcarry) else $error("shift carry wrong");

  property p_bitacc;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_BLD |=> ccr_r[`CCR_C] == $past(bv);
  endproperty
  a_bitacc: assert property (p_bitacc) else $error("bit load wrong");

  property p_sext;
    accumulator_upper_half_r[31:ACCUMULATOR_UPPER_HALF_W] == {(32 - ACCUMULATOR_UPPER_HALF_W){accumulator_upper_half_r[ACCUMULATOR_UPPER_HALF_W-1]}};
  endproperty
  a_sext: assert property (p_sext) else $error("upper half not sign extended");

  property p_vec;
    ce && seq_r == cpu_dp_pkg::ST_VEC && vec_valid
      |=> run && pc_r == ($past(vec_addr) & `ALIGN_MASK) && !exr_r[`EXR_T]
      && exr_r[`EXR_I_HI:`EXR_I_LO] == `EXR_RST && ccr_r[`CCR_I];
  endproperty
  a_vec: assert property (p_vec) else $error("reset exception load wrong");

  property p_align;
    ce && run && acc.valid && acc.size != cpu_dp_pkg::SZ_B && !req_valid
      |=> mem_req_r && mem_addr_r == ($past(acc_addr) & `ALIGN_MASK);
  endproperty
  a_align: assert property (p_align) else $error("access not aligned");

  property p_fetch;
    ce && run && acc.valid && acc.fetch && !req_valid |=> !mem_addr_r[0];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not aligned");

  property p_push;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_PUSH && req.size == cpu_dp_pkg::SZ_L
      |=> sp_r == $past(sp_r) - `STEP_L && mem_wr_r && mem_addr_r == (sp_r & `ALIGN_MASK);
  endproperty
  a_push: assert property (p_push) else $error("push not pre-decrement");

  property p_sync;
    ce && run && req_valid && req.op == cpu_dp_pkg::OP_SYNC_RD |=> bad_op_r && !done_r;
  endproperty
  a_sync: assert property (p_sync) else $error("unsupported op accepted");

  property p_mask;
    ce && ccr_r[`CCR_I] && !nmi_req ##1 ce |-> !irq_take_r;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt taken");
endmodule

// ===== verification/test_cpu_flags_mac_dp.sv
`timescale 1ns/10ps
module test_cpu_flags_mac_dp;
  typedef struct packed {
    cpu_dp_pkg::op_t op;
    cpu_dp_pkg::size_t sz;
    logic [31:0] a;
    logic [31:0] b;
    logic [2:0] bi;
    logic [31:0] res;
    logic res_on;
    logic [4:0] flg;
    logic [4:0] fmask;
  } row_t;
  localparam cpu_dp_pkg::size_t sz_b = cpu_dp_pkg::SZ_B;
  localparam cpu_dp_pkg::size_t sz_w = cpu_dp_pkg::SZ_W;
  localparam cpu_dp_pkg::size_t sz_l = cpu_dp_pkg::SZ_L;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic vec_valid = 1'b0;
  logic [31:0] vec_addr = 32'h1235;
  logic req_valid = 1'b0;
  cpu_dp_pkg::req_t req = '0;
  cpu_dp_pkg::acc_t acc = '0;
  logic exc_start = 1'b0;
  logic irq_req = 1'b0;
  logic nmi_req = 1'b0;
  logic [31:0] res_r, pc_r, sp_r, accumulator_upper_half_r, accumulator_lower_half_r, mem_addr_r;
  logic [7:0] ccr_r, exr_r;
  logic done_r, bad_op_r, mem_req_r, mem_wr_r, vec_req_r, irq_take_r;
  int bad_count = 0;
  int samples_checked = 0;
  logic [4:0] flg_seen;
  row_t rows [0:18];

  cpu_flags_mac_dp dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .req_valid(req_valid), .req(req), .acc(acc), .exc_start(exc_start),
    .irq_req(irq_req), .nmi_req(nmi_req), .res_r(res_r), .done_r(done_r), .bad_op_r(bad_op_r),
    .ccr_r(ccr_r), .exr_r(exr_r), .pc_r(pc_r), .sp_r(sp_r), .accumulator_upper_half_r(accumulator_upper_half_r), .accumulator_lower_half_r(accumulator_lower_half_r),
    .mem_addr_r(mem_addr_r), .mem_req_r(mem_req_r), .mem_wr_r(mem_wr_r),
    .vec_req_r(vec_req_r), .irq_take_r(irq_take_r));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One idle edge passes first, so a request never drops and rises in one time step.
  task automatic run_op(input cpu_dp_pkg::op_t op, input cpu_dp_pkg::size_t sz,
      input logic [31:0] a, input logic [31:0] b, input logic [2:0] bi);
    @(negedge clk);
    req = '{op, sz, a, b, bi};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic access(input logic [31:0] addr, input cpu_dp_pkg::size_t sz,
      input logic fetch, input logic [31:0] exp);
    @(negedge clk);
    acc = '{1'b1, addr, sz, fetch};
    @(negedge clk);
    acc.valid = 1'b0;
    chk("mem_req", {31'h0, mem_req_r}, 32'h1);
    chk("mem_addr", mem_addr_r, exp);
  endtask

  // Interrupt levels are held for exactly one sampling edge, then dropped.
  task automatic irq_step(input logic irq, input logic nmi, input logic exp);
    @(negedge clk);
    irq_req = irq;
    nmi_req = nmi;
    @(negedge clk);
    irq_req = 1'b0;
    nmi_req = 1'b0;
    chk("irq_take", {31'h0, irq_take_r}, {31'h0, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    #20000;
    bad_count++;
    complete_run();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  // Flag columns are {H, N, Z, V, C}; rows that depend on the previous flags
  // (decimal adjust, bit store) are placed right after the row that sets them.
  initial begin
    rows[0] = '{cpu_dp_pkg::OP_ADD, sz_b, 32'hff, 32'h1, 3'h0, 32'h0, 1'b1, 5'h15, 5'h1f};
    rows[1] = '{cpu_dp_pkg::OP_ADD, sz_b, 32'h7f, 32'h1, 3'h0, 32'h80, 1'b1, 5'h1a, 5'h1f};
    rows[2] = '{cpu_dp_pkg::OP_ADD, sz_w, 32'hffff, 32'h1, 3'h0, 32'h0, 1'b1, 5'h15, 5'h1f};
    rows[3] = '{cpu_dp_pkg::OP_ADD, sz_l, 32'h7fffffff, 32'h1, 3'h0, 32'h80000000, 1'b1,
      5'h1a, 5'h1f};
    rows[4] = '{cpu_dp_pkg::OP_ADD, sz_w, 32'h800, 32'h800, 3'h0, 32'h1000, 1'b1, 5'h10, 5'h1f};
    rows[5] = '{cpu_dp_pkg::OP_ADD, sz_l, 32'h8000000, 32'h8000000, 3'h0, 32'h10000000, 1'b1,
      5'h10, 5'h1f};
    rows[6] = '{cpu_dp_pkg::OP_SUB, sz_b, 32'h55, 32'h55, 3'h0, 32'h0, 1'b1, 5'h04, 5'h1f};
    rows[7] = '{cpu_dp_pkg::OP_DAA, sz_b, 32'h1a, 32'h1a, 3'h0, 32'h20, 1'b1, 5'h00, 5'h0c};
    rows[8] = '{cpu_dp_pkg::OP_SHLL, sz_b, 32'h80, 32'h80, 3'h0, 32'h0, 1'b1, 5'h05, 5'h0f};
    rows[9] = '{cpu_dp_pkg::OP_SHLR, sz_w, 32'h1, 32'h1, 3'h0, 32'h0, 1'b1, 5'h05, 5'h0f};
    rows[10] = '{cpu_dp_pkg::OP_AND, sz_l, 32'hf0f0f0f0, 32'h0f0f0f0f, 3'h0, 32'h0, 1'b1,
      5'h04, 5'h0e};
    rows[11] = '{cpu_dp_pkg::OP_XOR, sz_b, 32'hff, 32'h0f, 3'h0, 32'hf0, 1'b1, 5'h08, 5'h0e};
    rows[12] = '{cpu_dp_pkg::OP_NOT, sz_b, 32'h0f, 32'h0f, 3'h0, 32'hf0, 1'b1, 5'h08, 5'h0e};
    rows[13] = '{cpu_dp_pkg::OP_BLD, sz_b, 32'h08, 32'h08, 3'h3, 32'h0, 1'b0, 5'h01, 5'h01};
    rows[14] = '{cpu_dp_pkg::OP_BST, sz_b, 32'h0, 32'h0, 3'h5, 32'h20, 1'b1, 5'h00, 5'h00};
    rows[15] = '{cpu_dp_pkg::OP_CMP, sz_b, 32'h10, 32'h20, 3'h0, 32'h0, 1'b0, 5'h09, 5'h1f};
    rows[16] = '{cpu_dp_pkg::OP_NEG, sz_w, 32'h0, 32'h1, 3'h0, 32'hffff, 1'b1, 5'h19, 5'h1f};
    rows[17] = '{cpu_dp_pkg::OP_ROTR, sz_b, 32'h1, 32'h1, 3'h0, 32'h80, 1'b1, 5'h09, 5'h0f};
    rows[18] = '{cpu_dp_pkg::OP_BTST, sz_b, 32'h0, 32'h4, 3'h0, 32'h0, 1'b0, 5'h04, 5'h04};
    repeat (16) @(negedge clk);
    chk("exr_rst", {24'h0, exr_r}, 32'h7);
    chk("imask_rst", {31'h0, ccr_r[7]}, 32'h1);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("vec_req", {31'h0, vec_req_r}, 32'h1);
    vec_valid = 1'b1;
    @(negedge clk);
    vec_valid = 1'b0;
    @(negedge clk);
    chk("pc", pc_r, 32'h1234);
    chk("exr", {24'h0, exr_r}, 32'h7);
    chk("vec_done", {31'h0, vec_req_r}, 32'h0);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].sz, rows[i].a, rows[i].b, rows[i].bi);
      chk("done", {31'h0, done_r}, 32'h1);
      if (rows[i].res_on) chk("res", res_r, rows[i].res);
      flg_seen = {ccr_r[5], ccr_r[3:0]} & rows[i].fmask;
      chk("flags", {27'h0, flg_seen}, {27'h0, rows[i].flg});
    end
    access(32'h5, sz_w, 1'b0, 32'h4);
    access(32'h7, sz_l, 1'b0, 32'h6);
    access(32'h5, sz_b, 1'b0, 32'h5);
    access(32'h3, sz_b, 1'b1, 32'h2);
    run_op(cpu_dp_pkg::OP_LDSP, sz_l, 32'h1000, 32'h1000, 3'h0);
    run_op(cpu_dp_pkg::OP_PUSH, sz_w, 32'habcd, 32'habcd, 3'h0);
    chk("push_sp", sp_r, 32'h0ffe);
    chk("push_addr", mem_addr_r, 32'h0ffe);
    chk("push_wr", {31'h0, mem_wr_r}, 32'h1);
    run_op(cpu_dp_pkg::OP_POP, sz_l, 32'h0, 32'h0, 3'h0);
    chk("pop_addr", mem_addr_r, 32'h0ffe);
    chk("pop_sp", sp_r, 32'h1002);
    run_op(cpu_dp_pkg::OP_PUSH, sz_l, 32'h5a5a5a5a, 32'h0, 3'h0);
    chk("push_l_sp", sp_r, 32'h0ffe);
    chk("push_l_addr", mem_addr_r, 32'h0ffe);
    run_op(cpu_dp_pkg::OP_LDMACH, sz_l, 32'h200, 32'h200, 3'h0);
    chk("upper_neg", accumulator_upper_half_r, 32'hfffffe00);
    run_op(cpu_dp_pkg::OP_LDMACL, sz_l, 32'h12345678, 32'h12345678, 3'h0);
    chk("lower", accumulator_lower_half_r, 32'h12345678);
    run_op(cpu_dp_pkg::OP_LDMACH, sz_l, 32'h1ff, 32'h1ff, 3'h0);
    chk("upper_pos", accumulator_upper_half_r, 32'h1ff);
    run_op(cpu_dp_pkg::OP_CLRMAC, sz_l, 32'h0, 32'h0, 3'h0);
    chk("clr_hi", accumulator_upper_half_r, 32'h0);
    chk("clr_lo", accumulator_lower_half_r, 32'h0);
    run_op(cpu_dp_pkg::OP_MAC, sz_w, 32'h1, 32'hffff, 3'h0);
    chk("mac_hi", accumulator_upper_half_r, 32'hffffffff);
    run_op(cpu_dp_pkg::OP_STMACL, sz_l, 32'h0, 32'h0, 3'h0);
    chk("mac_lo", res_r, 32'hffffffff);
    run_op(cpu_dp_pkg::OP_SYNC_RD, sz_b, 32'h0, 32'h0, 3'h0);
    chk("bad_rd", {31'h0, bad_op_r}, 32'h1);
    run_op(cpu_dp_pkg::OP_SYNC_WR, sz_b, 32'h0, 32'h0, 3'h0);
    chk("bad_wr", {31'h0, bad_op_r}, 32'h1);
    irq_step(1'b1, 1'b0, 1'b0);
    irq_step(1'b0, 1'b1, 1'b1);
    run_op(cpu_dp_pkg::OP_LDC, sz_b, 32'h0, 32'h0, 3'h0);
    chk("imask_clr", {24'h0, ccr_r}, 32'h0);
    irq_step(1'b1, 1'b0, 1'b1);
    // A flag load that clears the mask meets an exception start: the set must win.
    req = '{cpu_dp_pkg::OP_LDC, sz_b, 32'h0, 32'h0, 3'h0};
    req_valid = 1'b1;
    exc_start = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    exc_start = 1'b0;
    chk("imask_exc", {31'h0, ccr_r[7]}, 32'h1);
    irq_step(1'b1, 1'b0, 1'b0);
    complete_run();
  end
endmodule
